// ### cmrb_pkg.sv
// Constants for the chiller serial register bank
package cmrb_pkg;
   localparam logic [15:0] ADDR_FIRST      = 16'h0030;
   localparam logic [15:0] ADDR_LAST       = 16'h0043;
   localparam logic [15:0] ADDR_CHANNEL_ONE_TEMP = 16'h0030;
   localparam logic [15:0] ADDR_CHANNEL_TWO_TEMP = 16'h0031;
   localparam logic [15:0] ADDR_RSVD       = 16'h0032;
   localparam logic [15:0] ADDR_CHANNEL_TWO_COND = 16'h0033;
   localparam logic [15:0] ADDR_CHANNEL_ONE_PRES = 16'h0034;
   localparam logic [15:0] ADDR_CHANNEL_TWO_PRES = 16'h0035;
   localparam logic [15:0] ADDR_CHANNEL_ONE_FLOW = 16'h0036;
   localparam logic [15:0] ADDR_CHANNEL_TWO_FLOW = 16'h0037;
   localparam logic [15:0] ADDR_DISP_1     = 16'h0038;
   localparam logic [15:0] ADDR_DISP_4     = 16'h003B;
   localparam logic [15:0] ADDR_STATUS     = 16'h003C;
   localparam logic [15:0] ADDR_ALARM_1    = 16'h003D;
   localparam logic [15:0] ADDR_ALARM_2    = 16'h003E;
   localparam logic [15:0] ADDR_ALARM_3    = 16'h003F;
   localparam logic [15:0] ADDR_CHANNEL_ONE_SET  = 16'h0040;
   localparam logic [15:0] ADDR_CHANNEL_TWO_SET  = 16'h0041;
   localparam logic [15:0] ADDR_OP_CMD     = 16'h0042;
   localparam logic [15:0] ADDR_DISP_SEL   = 16'h0043;
   // Clamp limits for measured values
   localparam logic [15:0] LIM_LO          = 16'hF334;
   localparam logic [15:0] LIM_HI          = 16'h0CCC;
   // Status bit positions
   localparam int          ST_RUN          = 0;
   localparam int          ST_STOP_ALM     = 1;
   localparam int          ST_CONT_ALM     = 2;
   localparam int          ST_MAINT        = 3;
   localparam int          ST_READY_1      = 4;
   localparam int          ST_READY_2      = 5;
   localparam int          ST_TEMP_OUT     = 6;
   localparam int          ST_EXT_TUNE     = 12;
   localparam int          ST_WARM_UP      = 13;
   localparam int          ST_STARTUP      = 14;
   localparam int          ST_ANTI_FREEZE  = 15;
   // Display selector item codes, one nibble per display word
   localparam logic [3:0]  DSEL_NONE       = 4'h0;
   localparam logic [3:0]  DSEL_AMBIENT    = 4'h1;
   localparam logic [3:0]  DSEL_EXT_TUNE   = 4'h2;
   localparam logic [3:0]  DSEL_HX_INLET   = 4'h3;
   localparam logic [3:0]  DSEL_MAINT      = 4'h4;
   localparam logic [3:0]  DSEL_HP_PRES    = 4'h5;
   localparam logic [15:0] EXT_TUNE_OFF    = 16'hF334;
   // Reset values and negative answer code
   localparam logic [15:0] RST_WORD        = 16'h0000;
   localparam logic [7:0]  ERR_BAD_ADDR    = 8'h02;
   localparam logic [7:0]  ERR_NONE        = 8'h00;
endpackage : cmrb_pkg

// ### cmrb_register_bank.sv
// Register bank of the chiller serial interface
`timescale 1ns/10ps
`default_nettype none
module cmrb_register_bank #(
   parameter logic [15:0] SET_MIN = 16'hFF38,
   parameter logic [15:0] SET_MAX = 16'h0320
) (
   input  wire logic        CLOCK_I,
   input  wire logic        RST_B_I,
   // Word access from the frame layer
   input  wire logic        REQ_I,
   input  wire logic        WE_I,
   input  wire logic [15:0] ADDR_I,
   input  wire logic [15:0] WDATA_I,
   output logic             ACK_O,
   output logic [15:0]      RDATA_O,
   output logic [7:0]       ERR_CODE_O,
   // Measurements, same clock domain
   input  wire logic [15:0] CHANNEL_ONE_TEMP_I,
   input  wire logic [15:0] CHANNEL_TWO_TEMP_I,
   input  wire logic [15:0] TEMP_OFFSET_I,
   input  wire logic        OFFSET_EN_I,
   input  wire logic [15:0] CHANNEL_TWO_COND_I,
   input  wire logic [15:0] CHANNEL_ONE_PRES_I,
   input  wire logic [15:0] CHANNEL_TWO_PRES_I,
   input  wire logic [15:0] CHANNEL_ONE_FLOW_I,
   input  wire logic [15:0] CHANNEL_TWO_FLOW_I,
   input  wire logic [15:0] AMBIENT_TEMP_I,
   input  wire logic [15:0] EXT_TUNE_TEMP_I,
   input  wire logic [15:0] HX_INLET_TEMP_I,
   input  wire logic [15:0] MAINT_NOTICE_I,
   input  wire logic [15:0] HP_PRES_I,
   // Unit state
   input  wire logic        RUNNING_I,
   input  wire logic        STOP_ALARM_I,
   input  wire logic        CONT_ALARM_I,
   input  wire logic        CHANNEL_ONE_READY_I,
   input  wire logic        CHANNEL_TWO_READY_I,
   input  wire logic        TEMP_OUT_I,
   input  wire logic        EXT_TUNE_EN_I,
   input  wire logic        WARM_UP_I,
   input  wire logic        STARTUP_I,
   input  wire logic        ANTI_FREEZE_I,
   input  wire logic [15:0] ALARM_1_I,
   input  wire logic [15:0] ALARM_2_I,
   input  wire logic [15:0] ALARM_3_I,
   // Master settings towards the unit
   output logic [15:0]      CHANNEL_ONE_SET_O,
   output logic [15:0]      CHANNEL_TWO_SET_O,
   output logic [15:0]      OP_CMD_O,
   output logic             OP_CMD_STB_O
);
   import cmrb_pkg::*;

   logic [15:0] channel_one_set_q, channel_one_set_d;
   logic [15:0] channel_two_set_q, channel_two_set_d;
   logic [15:0] op_cmd_q, op_cmd_d;
   logic [15:0] dsel_q, dsel_d;
   logic        op_stb_q, op_stb_d;
   logic        ack_q, ack_d;
   logic [15:0] rdata_q, rdata_d;
   logic [7:0]  err_q, err_d;
   logic [15:0] status_w;
   logic [15:0] disp_w [4];
   logic [15:0] temp1_w, temp2_w;
   logic [15:0] wclamp_w;

   // Limit a signed word to the measured span
   function automatic logic [15:0] clamp_meas(input logic [15:0] v);
      if ($signed(v) > $signed(LIM_HI)) begin
         return LIM_HI;
      end else if ($signed(v) < $signed(LIM_LO)) begin
         return LIM_LO;
      end
      return v;
   endfunction : clamp_meas

   // Reported temperature follows the panel, offset included
   assign temp1_w = clamp_meas(OFFSET_EN_I ? 16'(CHANNEL_ONE_TEMP_I + TEMP_OFFSET_I)
                                           : CHANNEL_ONE_TEMP_I);
   assign temp2_w = clamp_meas(OFFSET_EN_I ? 16'(CHANNEL_TWO_TEMP_I + TEMP_OFFSET_I)
                                           : CHANNEL_TWO_TEMP_I);

   // Status word; undefined bits held at zero
   always_comb begin
      status_w                 = RST_WORD;
      status_w[ST_RUN]         = RUNNING_I;
      status_w[ST_STOP_ALM]    = STOP_ALARM_I;
      status_w[ST_CONT_ALM]    = CONT_ALARM_I;
      status_w[ST_MAINT]       = |MAINT_NOTICE_I;
      status_w[ST_READY_1]     = CHANNEL_ONE_READY_I;
      status_w[ST_READY_2]     = CHANNEL_TWO_READY_I;
      status_w[ST_TEMP_OUT]    = TEMP_OUT_I;
      status_w[ST_EXT_TUNE]    = EXT_TUNE_EN_I;
      status_w[ST_WARM_UP]     = WARM_UP_I;
      status_w[ST_STARTUP]     = STARTUP_I;
      status_w[ST_ANTI_FREEZE] = ANTI_FREEZE_I;
   end

   // One selector nibble per display word; unknown items read zero
   for (genvar g = 0; g < 4; g++) begin : g_disp
      always_comb begin
         unique case (dsel_q[g*4 +: 4])
            DSEL_AMBIENT:  disp_w[g] = clamp_meas(AMBIENT_TEMP_I);
            DSEL_EXT_TUNE: disp_w[g] = EXT_TUNE_EN_I ? clamp_meas(EXT_TUNE_TEMP_I) : EXT_TUNE_OFF;
            DSEL_HX_INLET: disp_w[g] = clamp_meas(HX_INLET_TEMP_I);
            DSEL_MAINT:    disp_w[g] = MAINT_NOTICE_I;
            DSEL_HP_PRES:  disp_w[g] = clamp_meas(HP_PRES_I);
            default:       disp_w[g] = RST_WORD;
         endcase
      end
   end

   // Written set temperature is clamped, never rejected
   always_comb begin
      if ($signed(WDATA_I) > $signed(SET_MAX)) begin
         wclamp_w = SET_MAX;
      end else if ($signed(WDATA_I) < $signed(SET_MIN)) begin
         wclamp_w = SET_MIN;
      end else begin
         wclamp_w = WDATA_I;
      end
   end

   // Access decode: one answer per request, the cycle after it
   always_comb begin
      channel_one_set_d = channel_one_set_q;
      channel_two_set_d = channel_two_set_q;
      op_cmd_d  = op_cmd_q;
      dsel_d    = dsel_q;
      op_stb_d  = 1'b0;
      ack_d     = REQ_I;
      rdata_d   = rdata_q;
      err_d     = err_q;
      if (REQ_I) begin
         rdata_d = RST_WORD;
         err_d   = ERR_NONE;
         if (ADDR_I < ADDR_FIRST || ADDR_I > ADDR_LAST) begin
            err_d = ERR_BAD_ADDR;
         end else if (WE_I) begin
            // Read-only words silently keep their contents
            unique case (ADDR_I)
               ADDR_CHANNEL_ONE_SET: channel_one_set_d = wclamp_w;
               ADDR_CHANNEL_TWO_SET: channel_two_set_d = wclamp_w;
               ADDR_OP_CMD: begin
                  op_cmd_d = WDATA_I;
                  op_stb_d = 1'b1;
               end
               ADDR_DISP_SEL: dsel_d = WDATA_I;
               default:       rdata_d = RST_WORD;
            endcase
         end else begin
            unique case (ADDR_I)
               ADDR_CHANNEL_ONE_TEMP: rdata_d = temp1_w;
               ADDR_CHANNEL_TWO_TEMP: rdata_d = temp2_w;
               ADDR_RSVD:     rdata_d = RST_WORD;
               ADDR_CHANNEL_TWO_COND: rdata_d = CHANNEL_TWO_COND_I;
               ADDR_CHANNEL_ONE_PRES: rdata_d = clamp_meas(CHANNEL_ONE_PRES_I);
               ADDR_CHANNEL_TWO_PRES: rdata_d = clamp_meas(CHANNEL_TWO_PRES_I);
               ADDR_CHANNEL_ONE_FLOW: rdata_d = CHANNEL_ONE_FLOW_I;
               ADDR_CHANNEL_TWO_FLOW: rdata_d = CHANNEL_TWO_FLOW_I;
               ADDR_STATUS:   rdata_d = status_w;
               ADDR_ALARM_1:  rdata_d = ALARM_1_I;
               ADDR_ALARM_2:  rdata_d = ALARM_2_I;
               ADDR_ALARM_3:  rdata_d = ALARM_3_I;
               ADDR_CHANNEL_ONE_SET: rdata_d = channel_one_set_q;
               ADDR_CHANNEL_TWO_SET: rdata_d = channel_two_set_q;
               ADDR_OP_CMD:   rdata_d = op_cmd_q;
               ADDR_DISP_SEL: rdata_d = dsel_q;
               default:       rdata_d = disp_w[2'(ADDR_I - ADDR_DISP_1)];
            endcase
         end
      end
   end

   // State registers; no reset values are given, so all start at zero
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         channel_one_set_q <= RST_WORD;
         channel_two_set_q <= RST_WORD;
         op_cmd_q  <= RST_WORD;
         dsel_q    <= RST_WORD;
         op_stb_q  <= 1'b0;
         ack_q     <= 1'b0;
         rdata_q   <= RST_WORD;
         err_q     <= ERR_NONE;
      end else begin
         channel_one_set_q <= channel_one_set_d;
         channel_two_set_q <= channel_two_set_d;
         op_cmd_q  <= op_cmd_d;
         dsel_q    <= dsel_d;
         op_stb_q  <= op_stb_d;
         ack_q     <= ack_d;
         rdata_q   <= rdata_d;
         err_q     <= err_d;
      end
   end

   assign ACK_O        = ack_q;
   assign RDATA_O      = rdata_q;
   assign ERR_CODE_O   = err_q;
   assign CHANNEL_ONE_SET_O = channel_one_set_q;
   assign CHANNEL_TWO_SET_O = channel_two_set_q;
   assign OP_CMD_O     = op_cmd_q;
   assign OP_CMD_STB_O = op_stb_q;
endmodule : cmrb_register_bank
`default_nettype wire

// ### cmrb_master_model.sv
// Bus master model issuing single word accesses
`timescale 1ns/10ps
`default_nettype none
module cmrb_master_model (
   input  wire logic        CLOCK_I,
   input  wire logic        ACK_O,
   input  wire logic [15:0] RDATA_O,
   input  wire logic [7:0]  ERR_CODE_O,
   output logic             REQ_I,
   output logic             WE_I,
   output logic [15:0]      ADDR_I,
   output logic [15:0]      WDATA_I
);
   // Idle until the first access
   initial {REQ_I, WE_I, ADDR_I, WDATA_I} = 34'h0;
   // Whole words; released lines show the inverse so stale values never match
   task automatic xfer(input logic w, input logic [15:0] a, v, output logic [15:0] d, output logic [7:0] e);
      int n;
      n = 0;
      @(negedge CLOCK_I);
      {REQ_I, WE_I, ADDR_I, WDATA_I} = {1'b1, w, a, v};
      @(negedge CLOCK_I);
      {REQ_I, ADDR_I, WDATA_I} = {1'b0, ~a, ~v};
      while (ACK_O !== 1'b1 && n < 4) begin
         @(negedge CLOCK_I);
         n++;
      end
      {d, e} = (n < 4) ? {RDATA_O, ERR_CODE_O} : 24'hXXXXXX;
   endtask : xfer
endmodule : cmrb_master_model
`default_nettype wire

// ### cmrb_checker_assertions.sv
// Port checks for the chiller register bank
`timescale 1ns/10ps
`default_nettype none
module cmrb_checker
   import cmrb_pkg::*;
#(
   parameter logic [15:0] SET_MIN = 16'hFF38,
   parameter logic [15:0] SET_MAX = 16'h0320
) (
   input wire logic        CLOCK_I,
   input wire logic        RST_B_I,
   input wire logic        REQ_I,
   input wire logic        WE_I,
   input wire logic [15:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic        ACK_O,
   input wire logic [15:0] RDATA_O,
   input wire logic [7:0]  ERR_CODE_O,
   input wire logic [15:0] CHANNEL_ONE_SET_O,
   input wire logic [15:0] OP_CMD_O,
   input wire logic        OP_CMD_STB_O
);
   default clocking dc @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   // Request shapes at the taking edge
   sequence rd_s(logic [15:0] a); REQ_I && !WE_I && ADDR_I == a; endsequence
   sequence wr_s(logic [15:0] a); REQ_I && WE_I && ADDR_I == a; endsequence
   // Answers one edge after the request
   bad_addr_a: assert property (REQ_I && (ADDR_I < ADDR_FIRST || ADDR_I > ADDR_LAST) |=>
      ACK_O && ERR_CODE_O == ERR_BAD_ADDR && RDATA_O == 16'h0000) else $error("bad address answer");
   good_addr_a: assert property (REQ_I && ADDR_I >= ADDR_FIRST && ADDR_I <= ADDR_LAST |=>
      ACK_O && ERR_CODE_O == ERR_NONE) else $error("good address answer");
   rsvd_zero_a: assert property (rd_s(ADDR_RSVD) |=> RDATA_O == 16'h0000) else $error("reserved word");
   temp_limit_a: assert property (rd_s(ADDR_CHANNEL_ONE_TEMP) |=> $signed(RDATA_O) >= $signed(LIM_LO) &&
      $signed(RDATA_O) <= $signed(LIM_HI)) else $error("temperature span");
   pres_limit_a: assert property (rd_s(ADDR_CHANNEL_ONE_PRES) |=> $signed(RDATA_O) >= $signed(LIM_LO) &&
      $signed(RDATA_O) <= $signed(LIM_HI)) else $error("pressure span");
   unused_zero_a: assert property (rd_s(ADDR_STATUS) |=> RDATA_O[11:7] == 5'h00) else $error("status");
   // Stored settings and command strobe
   set_limit_a: assert property (wr_s(ADDR_CHANNEL_ONE_SET) |=>
      $signed(CHANNEL_ONE_SET_O) >= $signed(SET_MIN) && $signed(CHANNEL_ONE_SET_O) <= $signed(SET_MAX))
      else $error("set limit");
   op_strobe_a: assert property (wr_s(ADDR_OP_CMD) |=> OP_CMD_STB_O && OP_CMD_O == $past(WDATA_I))
      else $error("operation word");
   // Strobe and answer never appear without a request one edge earlier
   strobe_only_a: assert property (OP_CMD_STB_O |-> $past(REQ_I) && $past(WE_I) && $past(ADDR_I) == ADDR_OP_CMD)
      else $error("stray operation strobe");
   ack_only_a: assert property (ACK_O |-> $past(REQ_I)) else $error("stray answer");
endmodule : cmrb_checker
bind cmrb_register_bank cmrb_checker #(.SET_MIN(SET_MIN), .SET_MAX(SET_MAX)) i_chk (.*);
`default_nettype wire

// ### chiller_modbus_register_bank_tb.sv
// Self-checking bench for the chiller register bank
`timescale 1ns/10ps
`default_nettype none
module chiller_modbus_register_bank_tb;
   import cmrb_pkg::*;
   logic        CLOCK_I, RST_B_I, REQ_I, WE_I, ACK_O, OP_CMD_STB_O, OFFSET_EN_I, RUNNING_I, STOP_ALARM_I;
   logic        CONT_ALARM_I, CHANNEL_ONE_READY_I, CHANNEL_TWO_READY_I, TEMP_OUT_I, EXT_TUNE_EN_I;
   logic        WARM_UP_I, STARTUP_I, ANTI_FREEZE_I;
   logic [7:0]  ERR_CODE_O;
   logic [15:0] ADDR_I, WDATA_I, RDATA_O, CHANNEL_ONE_SET_O, CHANNEL_TWO_SET_O, OP_CMD_O, HP_PRES_I;
   logic [15:0] CHANNEL_ONE_TEMP_I, CHANNEL_TWO_TEMP_I, CHANNEL_TWO_COND_I, CHANNEL_ONE_PRES_I, CHANNEL_TWO_PRES_I;
   logic [15:0] TEMP_OFFSET_I, CHANNEL_ONE_FLOW_I, CHANNEL_TWO_FLOW_I, MAINT_NOTICE_I;
   logic [15:0] AMBIENT_TEMP_I, EXT_TUNE_TEMP_I, HX_INLET_TEMP_I, ALARM_1_I, ALARM_2_I, ALARM_3_I;
   logic [35:0] q[$];
   int          fails = 0;
   int          comparisons = 0;
   // Limits pinned here so the tables follow them
   cmrb_register_bank #(.SET_MIN(16'hFF38), .SET_MAX(16'h0320)) i_dut (.*);
   cmrb_master_model i_mst (.*);
   // Clock
   always #25 CLOCK_I = ~CLOCK_I;
   // Compare of any result word
   task automatic chk(input logic [15:0] g, x);
      comparisons++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   // One access; the answer code follows from the address alone
   task automatic acc(input logic w, input logic [15:0] a, v);
      logic [15:0] d;
      logic [7:0]  e;
      i_mst.xfer(w, a, v, d, e);
      chk({8'h00, e}, {8'h00, (a < ADDR_FIRST || a > ADDR_LAST) ? ERR_BAD_ADDR : ERR_NONE});
      if (!w) chk(d, v);
   endtask : acc
   // Queue entries are {write flag, address, data or expected word}
   task automatic run(input string name);
      foreach (q[i]) acc(q[i][32], q[i][31:16], q[i][15:0]);
      $display("test %s done", name);
   endtask : run
   // Status inputs laid out as the status word
   task automatic setst(input logic [15:0] p);
      {ANTI_FREEZE_I, STARTUP_I, WARM_UP_I, EXT_TUNE_EN_I} = p[15:12];
      {TEMP_OUT_I, CHANNEL_TWO_READY_I, CHANNEL_ONE_READY_I} = p[6:4];
      {CONT_ALARM_I, STOP_ALARM_I, RUNNING_I} = p[2:0];
      MAINT_NOTICE_I = {15'h0000, p[3]};
   endtask : setst
   // Verdict
   task automatic wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   // Test sequence
   initial begin
      {CLOCK_I, RST_B_I, OFFSET_EN_I, TEMP_OFFSET_I} = {3'h0, 16'h000A};
      setst(16'h0000);
      {CHANNEL_ONE_TEMP_I, CHANNEL_TWO_TEMP_I, CHANNEL_TWO_COND_I, CHANNEL_ONE_PRES_I, CHANNEL_TWO_PRES_I} =
         {16'h0123, 16'hF000, 16'h8000, 16'h7000, 16'hFFF0};
      {CHANNEL_ONE_FLOW_I, CHANNEL_TWO_FLOW_I} = {16'h8001, 16'h7FFF};
      {AMBIENT_TEMP_I, EXT_TUNE_TEMP_I, HX_INLET_TEMP_I, HP_PRES_I, ALARM_1_I, ALARM_2_I, ALARM_3_I} =
         {16'h0111, 16'h0222, 16'h0333, 16'h0555, 16'h8421, 16'h1248, 16'hFFFF};
      repeat (20) @(negedge CLOCK_I);
      RST_B_I = 1'b1;
      q = '{36'h0_0030_0123, 36'h0_0031_F334, 36'h0_0032_0000, 36'h0_0033_8000, 36'h0_0034_0CCC,
            36'h0_0035_FFF0, 36'h0_0036_8001, 36'h0_0037_7FFF, 36'h0_003D_8421, 36'h1_003D_0000,
            36'h0_003D_8421, 36'h0_003E_1248, 36'h0_003F_FFFF};
      run("measure");
      OFFSET_EN_I = 1'b1;
      q = '{36'h0_0030_012D};
      run("offset");
      setst(16'hAFD5);
      q = '{36'h0_003C_A055};
      run("status one");
      setst(16'h5F2A);
      q = '{36'h0_003C_502A, 36'h1_003C_0000, 36'h0_003C_502A, 36'h1_0043_4321, 36'h0_0038_0111,
            36'h0_0039_0222, 36'h0_003A_0333, 36'h0_003B_0001};
      run("status two");
      setst(16'h0000);
      q = '{36'h1_0043_0025, 36'h0_0038_0555, 36'h0_0039_F334, 36'h1_0043_00F0, 36'h0_0038_0000,
            36'h0_0039_0000, 36'h0_0043_00F0, 36'h1_0041_FFCE, 36'h0_0041_FFCE,
            36'h1_0041_8000, 36'h0_0041_FF38, 36'h1_0040_0400, 36'h0_0040_0320, 36'h1_0042_0001,
            36'h0_0042_0001, 36'h0_002F_0000, 36'h0_0044_0000, 36'h1_FFFF_1234};
      run("settings");
      chk(CHANNEL_ONE_SET_O, 16'h0320);
      chk(CHANNEL_TWO_SET_O, 16'hFF38);
      chk(OP_CMD_O, 16'h0001);
      RST_B_I = 1'b0;
      @(negedge CLOCK_I);
      RST_B_I = 1'b1;
      q = '{36'h0_0040_0000, 36'h0_0041_0000, 36'h0_0042_0000, 36'h0_0043_0000};
      run("reset");
      wrap_up();
   end
   // Cuts a hang short
   initial begin
      repeat (3000) @(posedge CLOCK_I);
      fails++;
      wrap_up();
   end
endmodule : chiller_modbus_register_bank_tb
`default_nettype wire
